// *** rtl/adcp_pkg.sv ***
// constants, timing and state encoding for the dram cycle controller
// assumes a 125 MHz single-clock host and one 1M x 32 dram module on pins
package adcp_pkg;

  localparam int CLK_NS = 8;

  function automatic int cyc_min(input int ns);
    return (ns <= CLK_NS) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  function automatic int cyc_max(input int ns);
    return (ns < CLK_NS) ? 1 : ns / CLK_NS;
  endfunction

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int ROW_W = 10;
  localparam int COL_W = 10;
  localparam int ADDR_W = ROW_W + COL_W;
  localparam int DATA_W = 32;
  localparam int TIMER_W = 18;
  localparam int AGE_W = 15;
  localparam int SYNC_STAGES = 2;
  localparam int INIT_CYCLES = 8;

  localparam int T_PWR_NS = 2000000;
  localparam int T_RASP_NS = 200000;
  localparam int T_REFI_NS = 15600;
  localparam int T_RAH_NS = 10;
  localparam int T_RCD_NS = 20;
  localparam int T_RAC_NS = 80;
  localparam int T_CAC_NS = 20;
  localparam int T_AA_NS = 40;
  localparam int T_CAS_NS = 20;
  localparam int T_CWL_NS = 20;
  localparam int T_WCH_NS = 15;
  localparam int T_DH_NS = 15;
  localparam int T_RAS_NS = 80;
  localparam int T_CSH_NS = 80;
  localparam int T_RP_NS = 60;
  localparam int T_CP_NS = 10;
  localparam int T_RHCP_NS = 45;
  localparam int T_CSR_NS = 5;
  localparam int T_CHR_NS = 15;

  localparam int C_RAH = cyc_min(T_RAH_NS);
  localparam int C_MUX = imax(1, cyc_min(T_RCD_NS) - C_RAH);
  localparam int C_RD = imax(cyc_min(T_RAC_NS) - cyc_min(T_RCD_NS),
    imax(cyc_min(T_CAC_NS), cyc_min(T_AA_NS))) + SYNC_STAGES;
  localparam int C_WR = imax(imax(cyc_min(T_CAS_NS), cyc_min(T_CWL_NS)),
    imax(cyc_min(T_WCH_NS), cyc_min(T_DH_NS)));
  localparam int C_RAS = cyc_min(T_RAS_NS);
  localparam int C_CSH = cyc_min(T_CSH_NS);
  localparam int C_RP = cyc_min(T_RP_NS);
  localparam int C_CPRE = imax(cyc_min(T_CP_NS), cyc_min(T_RHCP_NS));
  localparam int C_CSR = cyc_min(T_CSR_NS);
  localparam int C_CHR = cyc_min(T_CHR_NS);
  localparam int C_REFI = cyc_max(T_REFI_NS);
  // page op timer loads plus one; each state runs a cycle past its load, so an op can overrun the page limit by 3 cycles
  localparam int C_PAGE_OP = C_CPRE + C_MUX + C_RD + 1;

  typedef enum logic [11:0] {
    ST_PWR   = 12'h001,
    ST_IDLE  = 12'h002,
    ST_ROW   = 12'h004,
    ST_MUX   = 12'h008,
    ST_COL   = 12'h010,
    ST_CPRE  = 12'h020,
    ST_OPEN  = 12'h040,
    ST_PRE   = 12'h080,
    ST_CBR_C = 12'h100,
    ST_CBR_R = 12'h200,
    ST_CBR_H = 12'h400,
    ST_RREF  = 12'h800
  } adcp_state_t;

endpackage

// *** rtl/adcp_timer.sv ***
// down-counting delay timer; done while the count sits at zero
// assumes load and value come from logic on the same clock
`timescale 1ns/100ps
module adcp_timer #(
  parameter int W = 18
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] val_i,
  output logic done_o
);
  logic [W-1:0] count;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= val_i;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  assign done_o = (count == '0);
endmodule

// *** rtl/adcp_refresh.sv ***
// refresh interval ticker and host-side row counter
// assumes ack is a one-cycle pulse from the cycle sequencer
`timescale 1ns/100ps
module adcp_refresh #(
  parameter int INTERVAL = adcp_pkg::C_REFI,
  parameter int ROWS_W = adcp_pkg::ROW_W
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ack_i,
  output logic due_o,
  output logic [ROWS_W-1:0] row_o
);
  localparam int CNT_W = $clog2(INTERVAL + 1);
  logic [CNT_W-1:0] tick_cnt;
  logic tick;

  assign tick = (tick_cnt == CNT_W'(INTERVAL - 1));

  // one row per interval covers all rows inside the period
  // steady refresh leaves no idle gap needing a wakeup
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + CNT_W'(1);
    end
  end

  // a tick in the ack cycle is kept: set wins
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      due_o <= 1'b0;
    end else if (tick) begin
      due_o <= 1'b1;
    end else if (ack_i) begin
      due_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      row_o <= '0;
    end else if (ack_i) begin
      row_o <= row_o + ROWS_W'(1);
    end
  end
endmodule

// *** rtl/adcp_ctrl.sv ***
// host-side cycle sequencer for an asynchronous 1M x 32 dram module
// assumes dq_i comes from the pins and is synchronised here; one clock
`timescale 1ns/100ps
module adcp_ctrl #(
  parameter int PWR_CYC = adcp_pkg::cyc_min(adcp_pkg::T_PWR_NS),
  parameter int PAGE_CYC = adcp_pkg::cyc_max(adcp_pkg::T_RASP_NS)
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic req_i,
  input wire logic req_we_i,
  input wire logic [adcp_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [adcp_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic ref_row_only_i,
  output logic req_ready_o,
  output logic [adcp_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_valid_o,
  output logic init_done_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [adcp_pkg::ROW_W-1:0] addr_o,
  output logic [adcp_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [adcp_pkg::DATA_W-1:0] dq_i
);
  localparam int TW = adcp_pkg::TIMER_W;
  localparam int AW = adcp_pkg::AGE_W;
  localparam int RW = adcp_pkg::ROW_W;

  adcp_pkg::adcp_state_t state;
  adcp_pkg::adcp_state_t next_state;
  logic tload;
  logic [TW-1:0] tval;
  logic tdone;
  logic ref_due;
  logic ref_ack;
  logic [RW-1:0] ref_row;
  logic [AW-1:0] ras_age;
  logic [3:0] init_cnt;
  logic [RW-1:0] open_row;
  logic [RW-1:0] lat_col;
  logic lat_we;
  logic take;
  logic same_row;
  logic page_ok;
  logic pwr_armed;
  logic [adcp_pkg::DATA_W-1:0] dq_s1;
  logic [adcp_pkg::DATA_W-1:0] dq_s2;

  adcp_timer #(
    .W(TW)
  ) u_timer (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .load_i(tload),
    .val_i(tval),
    .done_o(tdone)
  );

  adcp_refresh #(
    .INTERVAL(adcp_pkg::C_REFI),
    .ROWS_W(RW)
  ) u_refresh (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ack_i(ref_ack),
    .due_o(ref_due),
    .row_o(ref_row)
  );

  // ****************************************
  // request acceptance
  // ****************************************
  assign same_row = (req_addr_i[adcp_pkg::ADDR_W-1:adcp_pkg::COL_W]
    == open_row);
  assign page_ok = (ras_age < AW'(PAGE_CYC - adcp_pkg::C_PAGE_OP));
  assign req_ready_o = init_done_o && !ref_due &&
    ((state == adcp_pkg::ST_IDLE) ||
     (state == adcp_pkg::ST_OPEN && same_row && page_ok));
  assign take = req_i && req_ready_o;
  assign ref_ack = (state == adcp_pkg::ST_IDLE) &&
    (next_state == adcp_pkg::ST_CBR_C || next_state == adcp_pkg::ST_RREF);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    tload = 1'b0;
    tval = '0;
    case (state)
      adcp_pkg::ST_PWR: begin
        // timer is idle at reset, so arm the pause first
        if (!pwr_armed) begin
          tload = 1'b1;
          tval = TW'(PWR_CYC);
        end else if (tdone) begin
          next_state = adcp_pkg::ST_IDLE;
        end
      end
      adcp_pkg::ST_IDLE: begin
        // init strobes are column-before-row refreshes
        if (!init_done_o || (ref_due && !ref_row_only_i)) begin
          next_state = adcp_pkg::ST_CBR_C;
          tload = 1'b1;
          tval = TW'(adcp_pkg::C_CSR);
        end else if (ref_due) begin
          next_state = adcp_pkg::ST_RREF;
          tload = 1'b1;
          tval = TW'(adcp_pkg::C_RAS);
        end else if (take) begin
          next_state = adcp_pkg::ST_ROW;
          tload = 1'b1;
          tval = TW'(adcp_pkg::C_RAH);
        end
      end
      adcp_pkg::ST_ROW: begin
        // column address only after row hold
        if (tdone) begin
          next_state = adcp_pkg::ST_MUX;
          tload = 1'b1;
          tval = TW'(adcp_pkg::C_MUX);
        end
      end
      adcp_pkg::ST_MUX: begin
        if (tdone) begin
          next_state = adcp_pkg::ST_COL;
          tload = 1'b1;
          tval = lat_we ? TW'(adcp_pkg::C_WR) : TW'(adcp_pkg::C_RD);
        end
      end
      adcp_pkg::ST_COL: begin
        // write keeps both strobes low past its lead
        if (tdone && ras_age >= AW'(adcp_pkg::C_CSH)) begin
          next_state = adcp_pkg::ST_CPRE;
          tload = 1'b1;
          tval = TW'(adcp_pkg::C_CPRE);
        end
      end
      adcp_pkg::ST_CPRE: begin
        if (tdone) begin
          next_state = adcp_pkg::ST_OPEN;
        end
      end
      adcp_pkg::ST_OPEN: begin
        if (take) begin
          next_state = adcp_pkg::ST_MUX;
          tload = 1'b1;
          tval = TW'(1);
        end else if (ras_age >= AW'(adcp_pkg::C_RAS)) begin
          // column is already high here
          next_state = adcp_pkg::ST_PRE;
          tload = 1'b1;
          tval = TW'(adcp_pkg::C_RP);
        end
      end
      adcp_pkg::ST_CBR_C: begin
        if (tdone) begin
          next_state = adcp_pkg::ST_CBR_R;
          tload = 1'b1;
          tval = TW'(adcp_pkg::C_CHR);
        end
      end
      adcp_pkg::ST_CBR_R: begin
        if (tdone) begin
          next_state = adcp_pkg::ST_CBR_H;
        end
      end
      adcp_pkg::ST_CBR_H, adcp_pkg::ST_RREF: begin
        if (tdone && ras_age >= AW'(adcp_pkg::C_RAS)) begin
          next_state = adcp_pkg::ST_PRE;
          tload = 1'b1;
          tval = TW'(adcp_pkg::C_RP);
        end
      end
      adcp_pkg::ST_PRE: begin
        if (tdone) begin
          next_state = adcp_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = adcp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= adcp_pkg::ST_PWR;
    end else begin
      state <= next_state;
    end
  end

  // power-up pause loads the shared timer once after reset release
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_armed <= 1'b0;
    end else begin
      pwr_armed <= 1'b1;
    end
  end

  // ****************************************
  // strobes, address and data pins
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ras_n_o <= 1'b1;
    end else begin
      ras_n_o <= !(next_state inside {adcp_pkg::ST_ROW, adcp_pkg::ST_MUX,
        adcp_pkg::ST_COL, adcp_pkg::ST_CPRE, adcp_pkg::ST_OPEN,
        adcp_pkg::ST_CBR_R, adcp_pkg::ST_CBR_H, adcp_pkg::ST_RREF});
    end
  end

  // column stays high during row-only refresh
  // column rises before any refresh, so no hidden refresh
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cas_n_o <= 1'b1;
    end else begin
      cas_n_o <= !(next_state inside {adcp_pkg::ST_COL,
        adcp_pkg::ST_CBR_C, adcp_pkg::ST_CBR_R});
    end
  end

  // write strobe low across column of a write and across its mux except the first mux cycle of a page write after a read,
  // and in the first mux cycle of a page read after a write, so it is high around every refresh row fall
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      we_n_o <= 1'b1;
      dq_oe_o <= 1'b0;
    end else begin
      we_n_o <= !(lat_we && (next_state inside {adcp_pkg::ST_MUX,
        adcp_pkg::ST_COL}));
      dq_oe_o <= lat_we && (next_state inside {adcp_pkg::ST_MUX,
        adcp_pkg::ST_COL});
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_o <= '0;
    end else if (ref_ack && ref_row_only_i) begin
      addr_o <= ref_row;
    end else if (take && state == adcp_pkg::ST_IDLE) begin
      addr_o <= req_addr_i[adcp_pkg::ADDR_W-1:adcp_pkg::COL_W];
    end else if (take) begin
      addr_o <= req_addr_i[adcp_pkg::COL_W-1:0];
    end else if (state == adcp_pkg::ST_ROW && tdone) begin
      addr_o <= lat_col;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dq_o <= '0;
    end else if (take) begin
      dq_o <= req_wdata_i;
    end
  end

  // ****************************************
  // request latch and row tracking
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lat_we <= 1'b0;
      lat_col <= '0;
      open_row <= '0;
    end else if (take) begin
      lat_we <= req_we_i;
      lat_col <= req_addr_i[adcp_pkg::COL_W-1:0];
      open_row <= req_addr_i[adcp_pkg::ADDR_W-1:adcp_pkg::COL_W];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ras_age <= '0;
    end else if (ras_n_o) begin
      ras_age <= '0;
    end else if (ras_age != '1) begin
      ras_age <= ras_age + AW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      init_cnt <= '0;
    end else if (state == adcp_pkg::ST_CBR_C && tdone &&
                 init_cnt != 4'(adcp_pkg::INIT_CYCLES)) begin
      init_cnt <= init_cnt + 4'h1;
    end
  end
  assign init_done_o = (init_cnt == 4'(adcp_pkg::INIT_CYCLES));

  // ****************************************
  // read data capture
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else begin
      dq_s1 <= dq_i;
      dq_s2 <= dq_s1;
    end
  end

  // sampled at the end of column low, past every access path
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= 1'b0;
      if (state == adcp_pkg::ST_COL && next_state == adcp_pkg::ST_CPRE
          && !lat_we) begin
        rdata_o <= dq_s2;
        rdata_valid_o <= 1'b1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_cbr_fall;
    $fell(ras_n_o) && !cas_n_o;
  endsequence

  // cycles of row low seen so far, saturating
  logic [3:0] chk_ras_low;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chk_ras_low <= '0;
    end else if (ras_n_o) begin
      chk_ras_low <= '0;
    end else if (chk_ras_low != '1) begin
      chk_ras_low <= chk_ras_low + 4'h1;
    end
  end

  property p_ras_low;
    $rose(ras_n_o) |-> chk_ras_low >= 4'(adcp_pkg::C_RAS);
  endproperty
  a_ras_low: assert property (p_ras_low) else $error("row low short");

  property p_ras_pre;
    $rose(ras_n_o) |-> ras_n_o [*8];
  endproperty
  a_ras_pre: assert property (p_ras_pre) else $error("precharge short");

  property p_cas_low;
    $fell(cas_n_o) |-> !cas_n_o [*3];
  endproperty
  a_cas_low: assert property (p_cas_low) else $error("column low short");

  property p_page_cp;
    ($rose(cas_n_o) && !ras_n_o) |-> cas_n_o [*2];
  endproperty
  a_page_cp: assert property (p_page_cp) else $error("column precharge");

  property p_read_we;
    ($fell(cas_n_o) && !ras_n_o && we_n_o) |-> we_n_o [*8];
  endproperty
  a_read_we: assert property (p_read_we) else $error("read strobe");

  property p_early_wr;
    $fell(we_n_o) |-> !ras_n_o && cas_n_o && dq_oe_o;
  endproperty
  a_early_wr: assert property (p_early_wr) else $error("early write");

  property p_wr_lead;
    ($fell(cas_n_o) && !we_n_o) |-> (!we_n_o && !cas_n_o) [*3];
  endproperty
  a_wr_lead: assert property (p_wr_lead) else $error("write lead");

  property p_cbr_we;
    s_cbr_fall |-> $past(we_n_o) && we_n_o ##1 we_n_o ##1 we_n_o;
  endproperty
  a_cbr_we: assert property (p_cbr_we) else $error("refresh write");

  property p_cbr_hold;
    s_cbr_fall |-> !$past(cas_n_o) && !cas_n_o ##1 !cas_n_o;
  endproperty
  a_cbr_hold: assert property (p_cbr_hold) else $error("refresh column");

  property p_page_end;
    $rose(ras_n_o) |-> cas_n_o && $past(cas_n_o);
  endproperty
  a_page_end: assert property (p_page_end) else $error("page end order");

  property p_row_hold;
    ($fell(ras_n_o) && cas_n_o) |-> ##1 $stable(addr_o) ##1 $stable(addr_o);
  endproperty
  a_row_hold: assert property (p_row_hold) else $error("row hold");

  property p_init;
    !init_done_o |-> !req_ready_o;
  endproperty
  a_init: assert property (p_init) else $error("access before init");
endmodule

// *** verif/adcp_dram_model.sv ***
// pin-level model of the dram module with a watch on host timing
// assumes strobes come from a synchronous host; times are in ns
`timescale 1ns/100ps
module adcp_dram_model (
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [9:0] addr_i,
  input wire logic [31:0] dq_i,
  input wire logic dq_oe_i,
  output logic [31:0] dq_o,
  output int viol_o,
  output int cbr_o,
  output int ror_o,
  output logic [9:0] ror_row_o,
  output logic [19:0] last_addr_o
);
  logic [31:0] mem [bit [19:0]];
  logic [19:0] loc;
  logic [9:0] row = '0;
  logic rd = 0;
  logic act = 0;
  logic seen = 0;
  logic cbr = 0;
  int cyc = 0;
  realtime t_rf = -1e3;
  realtime t_rr = -1e3;
  realtime t_cf = -1e3;
  realtime t_we = -1e3;

  initial begin
    viol_o = 0;
    cbr_o = 0;
    ror_o = 0;
    dq_o = 32'h5a5a_a5a5;
  end

  // ***************************************************
  // strobe edges
  // ***************************************************
  always @(negedge ras_n_i) begin
    if ($realtime - t_rr < 60.0) viol_o++;
    t_rf = $realtime;
    act = 1;
    seen = 0;
    cyc++;
    cbr = (cas_n_i === 1'b0);
    if (cbr) begin
      cbr_o++;
      if ($realtime - t_cf < 5.0 || $realtime - t_we < 10.0) viol_o++;
      if (we_n_i !== 1'b1) viol_o++;
    end else begin
      row = addr_i;
    end
  end

  always @(posedge ras_n_i) begin
    if (act) begin
      if ($realtime - t_rf < 80.0) viol_o++;
      if (cas_n_i === 1'b0) viol_o++;
      if (!seen && !cbr) begin
        ror_o++;
        ror_row_o = row;
      end
    end
    act = 0;
    t_rr = $realtime;
  end

  always @(negedge cas_n_i) begin
    t_cf = $realtime;
    if (ras_n_i === 1'b0) begin
      seen = 1;
      if ($realtime - t_rf < 20.0 || cyc < 8) viol_o++;
      loc = {row, addr_i};
      last_addr_o = loc;
      if (we_n_i === 1'b0) begin
        if (dq_oe_i !== 1'b1) viol_o++;
        mem[loc] = dq_i;
      end else begin
        rd = 1;
        // data only after the column access time, never earlier
        #20;
        if (rd) dq_o = mem.exists(loc) ? mem[loc] : 32'h0;
      end
    end
  end

  // released lines show the inverse, so a stale sample cannot pass
  always @(posedge cas_n_i) begin
    if (rd) dq_o = ~dq_o;
    rd = 0;
  end

  always @(we_n_i) begin
    if (rd) viol_o++;
    if (we_n_i === 1'b1 && $realtime - t_cf < 15.0) viol_o++;
    if (we_n_i === 1'b0 && cbr && act && $realtime - t_rf < 10.0) begin
      viol_o++;
    end
    t_we = $realtime;
  end
endmodule

// *** verif/adcp_ctrl_bench.sv ***
// self-checking bench: controller against the pin model
// assumes adcp_pkg is compiled first; short power wait and page limit
`timescale 1ns/100ps
module adcp_ctrl_bench;
  localparam int PWR = 20;
  localparam int PAGE = 60;
  typedef struct {
    logic we;
    logic [19:0] addr;
    logic [31:0] data;
    int lat;
  } adcp_op_t;
  logic clk_i = 0;
  logic arst_n_i = 0;
  logic req_i = 0;
  logic req_we_i = 0;
  logic ref_row_only_i = 0;
  logic [19:0] req_addr_i = '0;
  logic [31:0] req_wdata_i = '0;
  logic [31:0] rdata_o, dq_o, dq_i, mem_q;
  logic req_ready_o, rdata_valid_o, init_done_o, dq_oe_o;
  logic ras_n_o, cas_n_o, we_n_o;
  logic [9:0] addr_o, ror_row, r;
  logic [19:0] last_addr;
  logic [19:0] prev_addr = '0;
  logic prev_we = 0;
  int viol, cbr, ror, v0, n;
  int fails = 0;
  int compares = 0;
  // page reads follow a same-row op; lat 0 marks a write
  adcp_op_t ops [10] = '{
    '{1'b1, 20'h12345, 32'haaaa_5555, 0},
    '{1'b1, 20'h12346, 32'h0f1e_2d3c, 0},
    '{1'b0, 20'h12345, 32'haaaa_5555, 12},
    '{1'b1, 20'h3ff00, 32'h0123_4567, 0},
    '{1'b0, 20'h12346, 32'h0f1e_2d3c, 15},
    '{1'b0, 20'h3ff00, 32'h0123_4567, 15},
    '{1'b1, 20'h00000, 32'hffff_ffff, 0},
    '{1'b1, 20'hfffff, 32'h0000_0000, 0},
    '{1'b0, 20'hfffff, 32'h0000_0000, 12},
    '{1'b0, 20'h00000, 32'hffff_ffff, 15}};

  adcp_ctrl #(.PWR_CYC(PWR), .PAGE_CYC(PAGE)) dut_u (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .req_i(req_i), .req_we_i(req_we_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .ref_row_only_i(ref_row_only_i), .req_ready_o(req_ready_o),
    .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
    .init_done_o(init_done_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o),
    .we_n_o(we_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .dq_i(dq_i));
  adcp_dram_model mem_u (.ras_n_i(ras_n_o), .cas_n_i(cas_n_o),
    .we_n_i(we_n_o), .addr_i(addr_o), .dq_i(dq_o), .dq_oe_i(dq_oe_o),
    .dq_o(mem_q), .viol_o(viol), .cbr_o(cbr), .ror_o(ror),
    .ror_row_o(ror_row), .last_addr_o(last_addr));
  assign dq_i = dq_oe_o ? dq_o : mem_q;

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // ***************************************************
  // shared tasks
  // ***************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_hi(ref logic sig, input int lim);
    n = 0;
    while (sig !== 1'b1) begin
      @(negedge clk_i);
      n++;
      if (n > lim) begin
        check(32'h0, 32'h1);
        finish_test();
      end
    end
  endtask

  task automatic do_reset();
    arst_n_i = 0;
    repeat (4) @(posedge clk_i);
    #1 check({ras_n_o, cas_n_o, we_n_o, dq_oe_o, req_ready_o,
      init_done_o, rdata_valid_o}, 7'b1110000);
    v0 = cbr;
    arst_n_i = 1;
    for (int i = 0; i < PWR; i++) begin
      @(posedge clk_i);
      #1 check(ras_n_o, 1'b1);
    end
    wait_hi(init_done_o, 20000);
    repeat (20) @(posedge clk_i);
    #1 check(cbr - v0, 8);
  endtask

  task automatic do_op(input adcp_op_t op);
    // let an edge pass so a request is never dropped and raised at once
    @(posedge clk_i);
    #1 req_we_i = op.we;
    req_addr_i = op.addr;
    req_wdata_i = op.data;
    req_i = 1;
    wait_hi(req_ready_o, 4000);
    @(posedge clk_i);
    #1 req_i = 0;
    if (prev_we) check(last_addr, prev_addr);
    prev_we = op.we;
    prev_addr = op.addr;
    if (!op.we) begin
      n = 0;
      while (rdata_valid_o !== 1'b1 && n < 40) begin
        @(posedge clk_i);
        #1 n++;
      end
      check(n, op.lat);
      if (n == 40) finish_test();
      check(rdata_o, op.data);
      check(last_addr, op.addr);
      @(posedge clk_i);
      #1 check(rdata_valid_o, 1'b0);
    end
  endtask

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    do_reset();
    $display("test reset and init done");
    foreach (ops[i]) do_op(ops[i]);
    $display("test table done");
    v0 = cbr;
    repeat (adcp_pkg::C_REFI) @(posedge clk_i);
    #1 check(cbr - v0, 1);
    ref_row_only_i = 1;
    v0 = ror;
    n = 0;
    while (ror == v0 && n < 4000) begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n == 4000) check(32'h0, 32'h1);
    if (n == 4000) finish_test();
    r = ror_row;
    v0 = ror;
    repeat (adcp_pkg::C_REFI) @(posedge clk_i);
    #1 check(ror - v0, 1);
    r = r + 10'h1;
    check(ror_row, r);
    ref_row_only_i = 0;
    $display("test refresh done");
    check(viol, 0);
    // cut a write short: a second reset must restart power-up and init
    req_we_i = 1;
    req_addr_i = 20'h55555;
    req_i = 1;
    wait_hi(req_ready_o, 4000);
    @(posedge clk_i);
    #1 req_i = 0;
    repeat (3) @(posedge clk_i);
    #1 do_reset();
    prev_we = 0;
    do_op('{1'b0, 20'h12345, 32'haaaa_5555, 15});
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
